/* File: hdl/swr_pkg.sv */
package swr_pkg;
    localparam int TRUE_COLS   = 280;
    localparam int COLS        = TRUE_COLS + 1;
    localparam int ROWS        = 8;
    localparam int NIB_W       = 4;
    localparam int COL_W       = 9;
    localparam int BYTES_PER_COL = ROWS / 2;
    localparam int FRAME_PULSES  = COLS * BYTES_PER_COL;
    localparam int PIPE_FILL   = 4;
    localparam int CLK_NS      = 5;
    localparam int NOOE_NS     = 100;
    localparam int NOOE_CYC    = (NOOE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [NIB_W-1:0] DUMMY_ODD  = 4'he;
    localparam logic [NIB_W-1:0] DUMMY_EVEN = 4'h0;
    localparam logic [1:0] ROW_RST = 2'h0;
    localparam logic [COL_W-1:0] COL_RST = 9'h000;
    localparam logic STROBE_IDLE = 1'b1;
endpackage

/* File: hdl/swr_pair_if.sv */
`timescale 1ns/1ps
interface swr_pair_if;
    import swr_pkg::*;
    logic [ROWS*NIB_W-1:0] column;
    logic [1:0]            rowPair;
    logic [NIB_W-1:0]      oddNib;
    logic [NIB_W-1:0]      evenNib;
    modport mux (input column, input rowPair, output oddNib, output evenNib);
    modport ctl (output column, output rowPair, input oddNib, input evenNib);
endinterface

/* File: hdl/swr_row_pick.sv */
`timescale 1ns/1ps
module swr_row_pick
    import swr_pkg::*;
(
    swr_pair_if.mux pair
);
    // odd row 2k+1 sits at nibble 2k, even row 2k+2 at nibble 2k+1
    always_comb
    begin
        pair.oddNib  = pair.column[pair.rowPair*2*NIB_W +: NIB_W];
        pair.evenNib = pair.column[(pair.rowPair*2+1)*NIB_W +: NIB_W];
    end
endmodule

/* File: hdl/swr_readout.sv */
`timescale 1ns/1ps
// Contract
// - select one of 281 columns at once
// - pick odd and even row together
// - two 4-bit pixels form one byte
// - pixel restore independent of digital reset
// - frame is 1124 strobes, restart low
// - sample on fall, output on rise
// - odd nibble odd row, bit3 msb
// - drive outputs only while enable low; dataOe here is set while outEnableN is high
module swr_readout
    import swr_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // host pins, synchronous to clk
    input  wire logic                  arrayRestart,
    input  wire logic                  pixelStrobe,
    input  wire logic                  outEnableN,
    // converter results of the selected column, nibble 2k odd row 2k+1
    input  wire logic [ROWS*NIB_W-1:0] columnPixels,
    // column select to the array, restore pulse to the pixels
    output logic      [COL_W-1:0]      columnSel,
    output logic                       pixelRestore,
    // data pins
    output logic      [NIB_W-1:0]      odd_pixel_nibble,
    output logic      [NIB_W-1:0]      even_pixel_nibble,
    output logic      [2*NIB_W-1:0]    dataOe
);
    typedef struct packed {
        logic             strobePrev;
        logic [COL_W-1:0] col;
        logic [1:0]       row;
        logic [NIB_W-1:0] sampOdd;
        logic [NIB_W-1:0] sampEven;
        logic [NIB_W-1:0] outOdd;
        logic [NIB_W-1:0] outEven;
        logic             restore;
    } swr_state_t;

    // strobe history starts at its parked level, so release shows no false rise;
    // limitation: a strobe held low across release reads as one fall
    localparam swr_state_t ST_RST = '{strobePrev: STROBE_IDLE, col: COL_RST, row: ROW_RST,
                                      default: '0};

    swr_state_t st_reg;
    swr_state_t st_next;
    swr_pair_if pair ();

    swr_row_pick u_pick
    (
        .pair (pair)
    );

    logic strobeFall;
    logic strobeRise;
    logic dummyCol;

    assign pair.column  = columnPixels;
    assign pair.rowPair = st_reg.row;
    assign strobeFall   = st_reg.strobePrev & ~pixelStrobe;
    assign strobeRise   = ~st_reg.strobePrev & pixelStrobe;
    assign dummyCol     = (st_reg.col == COL_W'(TRUE_COLS));

    always_comb
    begin
        st_next            = st_reg;
        st_next.strobePrev = pixelStrobe;
        st_next.restore    = 1'b0;
        if (arrayRestart)
        begin
            // restart parks the scan at column 0, row pair 0
            st_next.col = COL_RST;
            st_next.row = ROW_RST;
        end
        else if (strobeFall)
        begin
            // dummy column carries a fixed sync pattern
            st_next.sampOdd  = dummyCol ? DUMMY_ODD : pair.oddNib;
            st_next.sampEven = dummyCol ? DUMMY_EVEN : pair.evenNib;
            if (st_reg.row == 2'(BYTES_PER_COL - 1))
            begin
                st_next.row = ROW_RST;
                // column restore starts its next integration period
                st_next.restore = 1'b1;
                if (st_reg.col == COL_W'(COLS - 1))
                    st_next.col = COL_RST;
                else
                    st_next.col = st_reg.col + 1'b1;
            end
            else
                st_next.row = st_reg.row + 1'b1;
        end
        if (strobeRise)
        begin
            st_next.outOdd  = st_reg.sampOdd;
            st_next.outEven = st_reg.sampEven;
        end
    end

    // pixel restore follows the scan only; nrst merely clears the flop
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_reg <= ST_RST;
        else
            st_reg <= st_next;
    end

    assign columnSel         = st_reg.col;
    assign pixelRestore      = st_reg.restore;
    assign odd_pixel_nibble  = st_reg.outOdd;
    assign even_pixel_nibble = st_reg.outEven;
    // dataOe follows outEnableN uninverted; all eight bits are set while outEnableN high
    assign dataOe            = {2*NIB_W{outEnableN}};

    // check bounds derived from the package, not new figures
    localparam logic [1:0]       LAST_PAIR = 2'(BYTES_PER_COL - 1);
    localparam logic [COL_W-1:0] LAST_COL  = COL_W'(COLS - 1);

    // a fall that the scan takes
    sequence s_fall_taken;
        strobeFall && !arrayRestart;
    endsequence

    // a taken fall on the last row pair of a column
    sequence s_col_done;
        strobeFall && !arrayRestart && st_reg.row == LAST_PAIR;
    endsequence

    // a taken fall on a true column
    sequence s_true_sample;
        strobeFall && !arrayRestart && !dummyCol;
    endsequence

    // a taken fall on the dummy column
    sequence s_dummy_sample;
        strobeFall && !arrayRestart && dummyCol;
    endsequence

    // scan order: pairs within a column, then columns, then wrap
    a_fall_advances: assert property (@(posedge clk) disable iff (!nrst)
        s_fall_taken ##0 (st_reg.row != LAST_PAIR)
        |=> st_reg.row == $past(st_reg.row) + 2'h1)
        else $error("row pair did not advance on strobe fall");

    a_col_advance: assert property (@(posedge clk) disable iff (!nrst)
        s_col_done ##0 (st_reg.col != LAST_COL)
        |=> st_reg.col == $past(st_reg.col) + 9'h001)
        else $error("column did not advance after its last pair");

    a_col_wrap: assert property (@(posedge clk) disable iff (!nrst)
        s_col_done ##0 (st_reg.col == LAST_COL)
        |=> st_reg.col == COL_RST && st_reg.row == ROW_RST)
        else $error("column did not wrap after the dummy column");

    a_col_bound: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.col <= LAST_COL)
        else $error("column index out of range");

    a_scan_held: assert property (@(posedge clk) disable iff (!nrst)
        !strobeFall && !arrayRestart
        |=> $stable(st_reg.col) && $stable(st_reg.row))
        else $error("scan moved without a strobe fall");

    // restart wins over a fall in the same cycle, so nothing is sampled
    a_restart_parks: assert property (@(posedge clk) disable iff (!nrst)
        arrayRestart
        |=> st_reg.col == COL_RST && st_reg.row == ROW_RST)
        else $error("restart did not park the scan");

    a_parked_quiet: assert property (@(posedge clk) disable iff (!nrst)
        arrayRestart
        |=> $stable(st_reg.sampOdd) && $stable(st_reg.sampEven))
        else $error("pixels sampled while restart high");

    // data path: sample on fall, present on rise
    a_rise_output: assert property (@(posedge clk) disable iff (!nrst)
        strobeRise |=> odd_pixel_nibble == $past(st_reg.sampOdd)
        && even_pixel_nibble == $past(st_reg.sampEven))
        else $error("byte not presented on strobe rise");

    a_rise_no_sample: assert property (@(posedge clk) disable iff (!nrst)
        strobeRise
        |=> $stable(st_reg.sampOdd) && $stable(st_reg.sampEven))
        else $error("pixels resampled on strobe rise");

    a_out_steady: assert property (@(posedge clk) disable iff (!nrst)
        !strobeRise |=> $stable(odd_pixel_nibble) && $stable(even_pixel_nibble))
        else $error("data changed without strobe rise");

    a_odd_sample: assert property (@(posedge clk) disable iff (!nrst)
        s_true_sample
        |=> st_reg.sampOdd == $past(columnPixels[st_reg.row*2*NIB_W +: NIB_W]))
        else $error("odd nibble from wrong row");

    a_even_sample: assert property (@(posedge clk) disable iff (!nrst)
        s_true_sample
        |=> st_reg.sampEven == $past(columnPixels[(st_reg.row*2+1)*NIB_W +: NIB_W]))
        else $error("even nibble from wrong row");

    a_dummy_sync: assert property (@(posedge clk) disable iff (!nrst)
        s_dummy_sample
        |=> st_reg.sampOdd == DUMMY_ODD && st_reg.sampEven == DUMMY_EVEN)
        else $error("dummy pattern wrong");

    // restore: one pulse per column, only after its last pair
    a_restore_pulse: assert property (@(posedge clk) disable iff (!nrst)
        pixelRestore |=> !pixelRestore)
        else $error("restore longer than one cycle");

    a_restore_source: assert property (@(posedge clk) disable iff (!nrst)
        pixelRestore
        |-> $past(strobeFall && !arrayRestart && st_reg.row == LAST_PAIR))
        else $error("restore without a finished column");

    // pins: dataOe copies outEnableN, uninverted, to all eight data bits
    a_hiz_enable: assert property (@(posedge clk) disable iff (!nrst)
        dataOe == {2*NIB_W{outEnableN}})
        else $error("output enable does not follow pin");
endmodule

/* File: tb/swr_host_model.sv */
`timescale 1ns/1ps
module swr_host_model
    import swr_pkg::*;
(
    // pins toward the sensor
    input  wire logic clk,
    output logic      arrayRestart,
    output logic      pixelStrobe,
    output logic      outEnableN
);
    localparam int SKIP_SLICES = 200;
    // strobes since the last restart, the host's only framing reference
    int   strobesSeen = 0;
    logic firstFrameDone;
    logic settled;
    // fill pulses and the whole first frame are thrown away
    assign firstFrameDone = (strobesSeen >= PIPE_FILL + FRAME_PULSES);
    // slices before this point are not trusted for matching
    assign settled        = (strobesSeen >= PIPE_FILL + SKIP_SLICES * FRAME_PULSES);
    // strobe parks high between pulses, outEnableN starts high
    initial
    begin
        arrayRestart = 1'b0;
        pixelStrobe  = 1'b1;
        outEnableN   = 1'b1;
    end
    task automatic hold(input logic v);
        @(negedge clk);
        arrayRestart = v;
    endtask
    // high for 20 cycles, twice the minimum
    task automatic restart();
        hold(1'b1);
        repeat (20) @(negedge clk);
        arrayRestart = 1'b0;
        strobesSeen  = 0;
    endtask
    // enable moves at the rise only, far from the sampling fall
    task automatic strobe(input logic oen);
        @(negedge clk);
        pixelStrobe = 1'b0;
        repeat (50) @(negedge clk);
        pixelStrobe = 1'b1;
        outEnableN  = oen;
        strobesSeen++;
        repeat (50) @(negedge clk);
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench;
    import swr_pkg::*;
    logic                  clk = 1'b0;
    logic                  nrst = 1'b0;
    logic                  arrayRestart, pixelStrobe, outEnableN, pixelRestore;
    logic [ROWS*NIB_W-1:0] columnPixels;
    logic [COL_W-1:0]      columnSel;
    logic [NIB_W-1:0]      oddNib, evenNib;
    logic [2*NIB_W-1:0]    dataOe;
    int                    bad_count = 0;
    int                    samples_checked = 0;
    int                    restores = 0;
    logic [NIB_W-1:0]      tint = 4'h0;
    always #2.5 clk = ~clk;
    // array answer tinted by column so a wrong column shows; tint is 0 until t_midreset sets 9
    always @(negedge clk) columnPixels <= 32'h76543210 ^ {8{columnSel[3:0] ^ tint}};
    // counted away from the launching edge, where the pulse is settled
    always @(negedge clk) if (pixelRestore === 1'b1) restores++;
    swr_host_model swr_host_model_i (.clk(clk), .arrayRestart(arrayRestart),
        .pixelStrobe(pixelStrobe), .outEnableN(outEnableN));
    swr_readout swr_readout_i (.clk(clk), .nrst(nrst), .arrayRestart(arrayRestart),
        .pixelStrobe(pixelStrobe), .outEnableN(outEnableN), .columnPixels(columnPixels),
        .columnSel(columnSel), .pixelRestore(pixelRestore), .odd_pixel_nibble(oddNib),
        .even_pixel_nibble(evenNib), .dataOe(dataOe));
    task automatic chk_byte(input int c, input int r);
        `CHK("odd", NIB_W'(2 * r) ^ NIB_W'(c) ^ tint, oddNib)
        `CHK("even", NIB_W'(2 * r + 1) ^ NIB_W'(c) ^ tint, evenNib)
    endtask
    task automatic t_reset();
        `CHK("columnSel", COL_RST, columnSel)
        `CHK("restore", 1'b0, pixelRestore)
        `CHK("data", 8'h00, {oddNib, evenNib})
        $display("test reset done");
    endtask
    task automatic t_scan();
        swr_host_model_i.restart();
        restores = 0;
        for (int n = 0; n < 16; n++)
        begin
            swr_host_model_i.strobe(1'b0);
            chk_byte(n / 4, n % 4);
            `CHK("columnSel", COL_W'((n + 1) / 4), columnSel)
        end
        `CHK("restores", 4, restores)
        `CHK("firstFrame", 1'b0, swr_host_model_i.firstFrameDone)
        `CHK("settled", 1'b0, swr_host_model_i.settled)
        $display("test scan done");
    endtask
    task automatic t_oe();
        swr_host_model_i.strobe(1'b1);
        `CHK("dataOe", 8'hff, dataOe)
        chk_byte(4, 0);
        swr_host_model_i.strobe(1'b0);
        `CHK("dataOe", 8'h00, dataOe)
        chk_byte(4, 1);
        $display("test enable done");
    endtask
    task automatic t_refuse();
        swr_host_model_i.hold(1'b1);
        repeat (2) swr_host_model_i.strobe(1'b0);
        `CHK("columnSel", COL_RST, columnSel)
        swr_host_model_i.hold(1'b0);
        swr_host_model_i.strobe(1'b0);
        chk_byte(0, 0);
        $display("test parked done");
    endtask
    task automatic t_midreset();
        tint = 4'h9;
        swr_host_model_i.strobe(1'b0);
        chk_byte(0, 1);
        @(negedge clk);
        nrst = 1'b0;
        repeat (10) @(negedge clk);
        `CHK("data", 8'h00, {oddNib, evenNib})
        nrst = 1'b1;
        `CHK("columnSel", COL_RST, columnSel)
        repeat (2) @(negedge clk);
        `CHK("data", 8'h00, {oddNib, evenNib})
        `CHK("restore", 1'b0, pixelRestore)
        swr_host_model_i.strobe(1'b0);
        chk_byte(0, 0);
        $display("test midreset done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_scan();
        t_oe();
        t_refuse();
        t_midreset();
        give_verdict();
    end
endmodule
